// ==== include/rtcr_consts.vh ====
/*
 Constants for the remote temperature configuration register bank.
 Assumes inclusion by bare name from design files.
*/
`ifndef RTCR_CONSTS_VH
`define RTCR_CONSTS_VH
`define RTCR_CMD_CONFIG      8'h03
`define RTCR_CMD_ONE_SHOT    8'h0f
`define RTCR_CMD_R1_HIGH     8'h19
`define RTCR_CMD_R2_HIGH     8'h1a
`define RTCR_CMD_R1_LOW      8'h29
`define RTCR_CMD_R2_LOW      8'h2a
`define RTCR_CMD_MODEL_SEL   8'h30
`define RTCR_CMD_R1_OFFSET   8'h31
`define RTCR_CMD_R2_OFFSET   8'h32
`define RTCR_CONFIG_RESET    8'h00
`define RTCR_MODEL_RESET     8'h02
`define RTCR_OFFSET_RESET    8'h00
`define RTCR_STANDBY_BIT     6
`define RTCR_MODEL_R1_BIT    1
`define RTCR_MODEL_R2_BIT    2
`define RTCR_FILTER_OFF      2'b00
`define RTCR_LOW_KEEP_MASK   8'he0
`define RTCR_LOW_FILT_MASK   8'hf8
`endif

// ==== rtl/rtcr_channel.v ====
/*
 One remote channel: applies the offset to the raw result and holds the
 corrected value in 1/32 degree units (13 bits: 8 integer, 5 fraction).
 Assumes raw results arrive as one-cycle strobes on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcr_channel (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        raw_valid,
    input  wire [12:0] raw_value,
    input  wire [7:0]  offset,
    output reg  [12:0] value_r
);
    reg  [13:0] sum;

    // Offset is 0.5 degree units, so shift by four to reach 1/32 units
    always @* begin
        sum = {1'b0, raw_value} + {{2{offset[7]}}, offset, 4'h0};
    end

    // Update only on a finished conversion; bit 13 is a borrow for a
    // negative offset and a carry for a positive one, so both clamp
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            value_r <= 13'h0000;
        end else if (raw_valid) begin
            if (offset[7] && sum[13])
                value_r <= 13'h0000; // Below zero after the offset
            else if (!offset[7] && sum[13])
                value_r <= 13'h1fff;
            else
                value_r <= sum[12:0];
        end
    end
endmodule // rtcr_channel
`default_nettype wire

// ==== rtl/rtcr_regs.v ====
/*
 Register bank for the unsigned remote results, diode model select,
 offset correction and main configuration. Each remote channel adds its
 offset to the raw result and keeps the corrected value; a high byte read
 freezes the matching low byte until that low byte is read.
 Command codes handled here:
   0x03       main configuration, only the standby bit is stored
   0x0f       one-shot, write only, the data byte is dropped
   0x19, 0x1a remote high bytes, read only
   0x29, 0x2a remote low bytes, read only, frozen by a high byte read
   0x30       diode model select, bits 2 and 1 stored
   0x31, 0x32 remote offsets, two's complement in half degrees
 Assumes an SMBus target engine on the same clock that decodes the bus:
 wr_stb/rd_stb pulse for one cycle with cmd_code (and wr_data), never
 both in one cycle. Filter fields come from the filter setting register
 outside this block and conv_busy from the conversion sequencer, both on
 clk_sys, so neither passes a synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcr_consts.vh"
module rtcr_regs (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        wr_stb,
    input  wire        rd_stb,
    input  wire [7:0]  cmd_code,
    input  wire [7:0]  wr_data,
    output reg  [7:0]  rd_data_r,
    output reg         rd_hit_r,
    input  wire [1:0]  remote1_filter_field,
    input  wire [1:0]  remote2_filter_field,
    input  wire        raw1_valid,
    input  wire [12:0] raw1_value,
    input  wire        raw2_valid,
    input  wire [12:0] raw2_value,
    input  wire        conv_busy,
    output wire        soft_standby_bit,
    output wire        remote1_beta_comp_select,
    output wire        remote2_beta_comp_select,
    output wire [7:0]  remote1_offset,
    output wire [7:0]  remote2_offset,
    output reg         one_shot_start_r
);
    reg  [7:0]  config_r;
    reg  [7:0]  model_r;
    reg  [7:0]  off1_r;
    reg  [7:0]  off2_r;
    reg  [7:0]  low1_lock_r;
    reg  [7:0]  low2_lock_r;
    reg         lock1_r;
    reg         lock2_r;
    reg  [7:0]  rd_nxt;
    reg         hit_nxt;
    wire [12:0] val1;
    wire [12:0] val2;
    wire [7:0]  low1_live;
    wire [7:0]  low2_live;
    wire        wr_cfg;
    wire        wr_model;
    wire        wr_off1;
    wire        wr_off2;
    wire        wr_shot;
    wire        rd_hi1;
    wire        rd_hi2;
    wire        rd_lo1;
    wire        rd_lo2;
    reg  [7:0]  config_nxt;
    reg  [7:0]  model_nxt;
    reg  [7:0]  off1_nxt;
    reg  [7:0]  off2_nxt;
    reg  [7:0]  low1_lock_nxt;
    reg  [7:0]  low2_lock_nxt;
    reg         lock1_nxt;
    reg         lock2_nxt;
    reg         one_shot_start_nxt;

    // Low byte from a 13-bit value; extra fraction only while filtering
    function [7:0] low_byte;
        input [12:0] v;
        input [1:0]  filt;
        begin
            if (filt == `RTCR_FILTER_OFF)
                low_byte = {v[4:0], 3'h0} & `RTCR_LOW_KEEP_MASK;
            else
                low_byte = {v[4:0], 3'h0} & `RTCR_LOW_FILT_MASK;
        end
    endfunction

    // Strobe qualified by one command code; shared by read and write decode
    function cmd_match;
        input       stb;
        input [7:0] cmd;
        input [7:0] code;
        begin
            cmd_match = stb && (cmd == code);
        end
    endfunction

    // Held low byte while frozen, live one otherwise
    function [7:0] pick_low;
        input       lock;
        input [7:0] held;
        input [7:0] live;
        begin
            pick_low = lock ? held : live;
        end
    endfunction

    rtcr_channel u_ch1 (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .raw_valid (raw1_valid),
        .raw_value (raw1_value),
        .offset    (off1_r),
        .value_r   (val1)
    );

    rtcr_channel u_ch2 (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .raw_valid (raw2_valid),
        .raw_value (raw2_value),
        .offset    (off2_r),
        .value_r   (val2)
    );

    assign low1_live = low_byte(val1, remote1_filter_field);
    assign low2_live = low_byte(val2, remote2_filter_field);

    // Write decode; value registers have no write path at all
    assign wr_cfg   = cmd_match(wr_stb, cmd_code, `RTCR_CMD_CONFIG);
    assign wr_model = cmd_match(wr_stb, cmd_code, `RTCR_CMD_MODEL_SEL);
    assign wr_off1  = cmd_match(wr_stb, cmd_code, `RTCR_CMD_R1_OFFSET);
    assign wr_off2  = cmd_match(wr_stb, cmd_code, `RTCR_CMD_R2_OFFSET);
    assign wr_shot  = cmd_match(wr_stb, cmd_code, `RTCR_CMD_ONE_SHOT);

    // Read decode for the low byte freeze
    assign rd_hi1   = cmd_match(rd_stb, cmd_code, `RTCR_CMD_R1_HIGH);
    assign rd_hi2   = cmd_match(rd_stb, cmd_code, `RTCR_CMD_R2_HIGH);
    assign rd_lo1   = cmd_match(rd_stb, cmd_code, `RTCR_CMD_R1_LOW);
    assign rd_lo2   = cmd_match(rd_stb, cmd_code, `RTCR_CMD_R2_LOW);

    // Next values of the writable registers; reserved bits are never stored
    always @* begin
        config_nxt = config_r;
        model_nxt  = model_r;
        off1_nxt   = off1_r;
        off2_nxt   = off2_r;
        if (wr_cfg) begin
            config_nxt = {1'b0, wr_data[`RTCR_STANDBY_BIT], 6'h00};
        end
        if (wr_model) begin
            model_nxt = {5'h00, wr_data[`RTCR_MODEL_R2_BIT],
                         wr_data[`RTCR_MODEL_R1_BIT], 1'b0};
        end
        if (wr_off1) begin
            off1_nxt = wr_data;
        end
        if (wr_off2) begin
            off2_nxt = wr_data;
        end
    end

    // Writable registers; the defaults return on every reset
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            config_r <= `RTCR_CONFIG_RESET;
            model_r  <= `RTCR_MODEL_RESET;
            off1_r   <= `RTCR_OFFSET_RESET;
            off2_r   <= `RTCR_OFFSET_RESET;
        end else begin
            config_r <= config_nxt;
            model_r  <= model_nxt;
            off1_r   <= off1_nxt;
            off2_r   <= off2_nxt;
        end
    end

    // One-shot request: data ignored; dropped outside standby or while the
    // sequencer runs, so a write never stacks a second sequence
    always @* begin
        one_shot_start_nxt = 1'b0;
        if (wr_shot && config_r[`RTCR_STANDBY_BIT] && !conv_busy) begin
            one_shot_start_nxt = 1'b1;
        end
    end

    // Registered start pulse, one cycle wide
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            one_shot_start_r <= 1'b0;
        end else begin
            one_shot_start_r <= one_shot_start_nxt;
        end
    end

    // Low byte freeze: a high read captures, a low read releases; a
    // repeated high read captures again and overrides the held byte
    always @* begin
        lock1_nxt     = lock1_r;
        lock2_nxt     = lock2_r;
        low1_lock_nxt = low1_lock_r;
        low2_lock_nxt = low2_lock_r;
        if (rd_hi1) begin
            lock1_nxt     = 1'b1;
            low1_lock_nxt = low1_live;
        end else if (rd_lo1) begin
            lock1_nxt = 1'b0;
        end
        if (rd_hi2) begin
            lock2_nxt     = 1'b1;
            low2_lock_nxt = low2_live;
        end else if (rd_lo2) begin
            lock2_nxt = 1'b0;
        end
    end

    // Freeze state; the held byte stays after release but is not used
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lock1_r     <= 1'b0;
            lock2_r     <= 1'b0;
            low1_lock_r <= 8'h00;
            low2_lock_r <= 8'h00;
        end else begin
            lock1_r     <= lock1_nxt;
            lock2_r     <= lock2_nxt;
            low1_lock_r <= low1_lock_nxt;
            low2_lock_r <= low2_lock_nxt;
        end
    end

    // Read mux; unknown commands answer zero and no hit
    always @* begin
        rd_nxt  = 8'h00;
        hit_nxt = 1'b1;
        case (cmd_code)
            `RTCR_CMD_CONFIG: begin
                rd_nxt = config_r;
            end
            `RTCR_CMD_R1_HIGH: begin
                rd_nxt = val1[12:5];
            end
            `RTCR_CMD_R2_HIGH: begin
                rd_nxt = val2[12:5];
            end
            `RTCR_CMD_R1_LOW: begin
                rd_nxt = pick_low(lock1_r, low1_lock_r, low1_live);
            end
            `RTCR_CMD_R2_LOW: begin
                rd_nxt = pick_low(lock2_r, low2_lock_r, low2_live);
            end
            `RTCR_CMD_MODEL_SEL: begin
                rd_nxt = model_r;
            end
            `RTCR_CMD_R1_OFFSET: begin
                rd_nxt = off1_r;
            end
            `RTCR_CMD_R2_OFFSET: begin
                rd_nxt = off2_r;
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // Read data registered on the read strobe and held until the next
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_r <= 8'h00;
            rd_hit_r  <= 1'b0;
        end else if (rd_stb) begin
            rd_data_r <= rd_nxt;
            rd_hit_r  <= hit_nxt;
        end
    end

    // Control outputs straight from the stored bits
    assign soft_standby_bit         = config_r[`RTCR_STANDBY_BIT];
    assign remote1_beta_comp_select = model_r[`RTCR_MODEL_R1_BIT];
    assign remote2_beta_comp_select = model_r[`RTCR_MODEL_R2_BIT];
    assign remote1_offset           = off1_r;
    assign remote2_offset           = off2_r;
endmodule // rtcr_regs
`default_nettype wire

// ==== bench/rtcr_regs_assertions.sv ====
/* Checker for the remote result register bank, bound to its ports.
   Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module rtcr_regs_assertions (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data_r,
    input wire logic [1:0] remote1_filter_field,
    input wire logic       conv_busy,
    input wire logic       soft_standby_bit,
    input wire logic       remote1_beta_comp_select,
    input wire logic       remote2_beta_comp_select,
    input wire logic [7:0] remote2_offset,
    input wire logic       one_shot_start_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Decoded requests; a shot only counts in standby with the sequencer idle
    wire wcfg = wr_stb && cmd_code == 8'h03;
    wire shot = wr_stb && cmd_code == 8'h0f && soft_standby_bit && !conv_busy;
    property p_soft_standby_bit_set; wcfg |=> soft_standby_bit == $past(wr_data[6]); endproperty
    a_soft_standby_bit_set: assert property (p_soft_standby_bit_set) else $error("standby not written");
    property p_soft_standby_bit_hold; !wcfg |=> $stable(soft_standby_bit); endproperty
    a_soft_standby_bit_hold: assert property (p_soft_standby_bit_hold) else $error("standby moved");
    property p_shot; shot |=> one_shot_start_r ##1 !one_shot_start_r; endproperty
    a_shot: assert property (p_shot) else $error("one-shot missing");
    property p_shot_cause; one_shot_start_r |-> $past(shot); endproperty
    a_shot_cause: assert property (p_shot_cause) else $error("stray one-shot");
    property p_model; wr_stb && cmd_code == 8'h30 |=>
        {remote2_beta_comp_select, remote1_beta_comp_select} == $past(wr_data[2:1]); endproperty
    a_model: assert property (p_model) else $error("model bits wrong");
    property p_off_hold; !(wr_stb && cmd_code == 8'h32) |=> $stable(remote2_offset); endproperty
    a_off_hold: assert property (p_off_hold) else $error("offset moved");
    property p_low_filt; rd_stb && cmd_code == 8'h29 && remote1_filter_field == 2'b00
        |=> rd_data_r[4:0] == 5'h00; endproperty
    a_low_filt: assert property (p_low_filt) else $error("low bits not zero");
    property p_cfg_rd; rd_stb && cmd_code == 8'h03 |=>
        rd_data_r == {1'b0, $past(soft_standby_bit), 6'h00}; endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
endmodule // rtcr_regs_assertions
`default_nettype wire

// ==== bench/rtcr_host.sv ====
/* Host model: issues one-cycle register reads and writes by command byte.
   Assumes clk_sys from the bench; signals change 1 ns after an edge. */
`timescale 1ns/1ps
`default_nettype none
module rtcr_host (
    input  wire logic       clk_sys,
    output var  logic       wr_stb,
    output var  logic       rd_stb,
    output var  logic [7:0] cmd_code,
    output var  logic [7:0] wr_data
);
    initial {wr_stb, rd_stb, cmd_code, wr_data} = 18'h0;
    // Strobe held one edge, then released; idle bus shows inverted garbage
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
        @(posedge clk_sys) #1;
        {wr_stb, rd_stb, cmd_code, wr_data} = {w, !w, c, d};
        @(posedge clk_sys) #1;
        {wr_stb, rd_stb, cmd_code, wr_data} = {2'b00, ~c, ~d};
    endtask
endmodule // rtcr_host
`default_nettype wire

// ==== bench/rtcr_regs_tb.sv ====
/* Self-checking bench for the remote result register bank.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module rtcr_regs_tb;
    logic clk_sys = 0, sys_rst = 1, raw1_valid = 0, raw2_valid = 0, conv_busy = 0;
    logic [1:0] remote1_filter_field = 0, remote2_filter_field = 0;
    logic [12:0] raw1_value = 0, raw2_value = 0, a, b, x, y;
    logic [7:0] cmd_code, wr_data, rd_data_r, remote1_offset, remote2_offset, o1, o2;
    logic wr_stb, rd_stb, rd_hit_r, soft_standby_bit, one_shot_start_r, pend;
    logic remote1_beta_comp_select, remote2_beta_comp_select;
    logic [8:0] expq[$];
    int error_cnt = 0, n_checks = 0, seed = 98775, shots = 0;
    always #12.5 clk_sys = ~clk_sys;
    rtcr_host i_host (.*);
    rtcr_regs i_dut (.*);
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: output %h expected %h", $time, got, exp);
        end
    endtask
    // Start pulses counted as the design's flops would see them
    always @(posedge clk_sys) if (one_shot_start_r === 1'b1) shots++;
    // Read answers land on the edge that takes the strobe
    always @(posedge clk_sys) begin
        pend = rd_stb;
        #2;
        if (pend)
            cmp({rd_hit_r, rd_data_r}, expq.pop_front());
    end
    task automatic rd(input logic [7:0] c, input logic [7:0] d, input logic h = 1);
        expq.push_back({h, d});
        i_host.xfer(0, c, 8'h00);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        i_host.xfer(1, c, d);
    endtask
    task automatic conv(input logic [12:0] p, input logic [12:0] q);
        @(posedge clk_sys) #1;
        {raw1_valid, raw2_valid, raw1_value, raw2_value} = {2'b11, p, q};
        @(posedge clk_sys) #1;
        {raw1_valid, raw2_valid} = 2'b00;
    endtask
    // Offset is half degrees, result 1/32 degree, clamped to the unsigned range
    function automatic logic [12:0] ev(input logic [12:0] r, input logic [7:0] o);
        int s;
        s = int'(r) + 16 * int'($signed(o));
        return s < 0 ? 13'h0000 : (s > 8191 ? 13'h1fff : 13'(s));
    endfunction
    function automatic logic [7:0] lo(input logic [12:0] v, input logic [1:0] f);
        return {v[4:0], 3'b000} & (f == 2'b00 ? 8'he0 : 8'hf8);
    endfunction
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 sys_rst = 0;
        rd(8'h03, 8'h00);
        rd(8'h30, 8'h02);
        rd(8'h32, 8'h00);
        rd(8'h77, 8'h00, 0);
        wr(8'h03, 8'hbf);
        rd(8'h03, 8'h00);
        wr(8'h0f, 8'h5a);
        wr(8'h03, 8'hff);
        cmp_out(8'(shots), 8'h00);
        cmp_out({7'h00, soft_standby_bit}, 8'h01);
        rd(8'h03, 8'h40);
        wr(8'h0f, 8'ha5);
        conv_busy = 1;
        wr(8'h0f, 8'h00);
        conv_busy = 0;
        cmp_out(8'(shots), 8'h01);
        wr(8'h30, 8'hff);
        cmp_out({6'h00, remote2_beta_comp_select, remote1_beta_comp_select}, 8'h03);
        rd(8'h30, 8'h06);
        wr(8'h30, 8'h00);
        rd(8'h30, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {o1, o2, a, b} = 42'({$random(seed), $random(seed)});
            // Filter code 10 is reserved, so only 00, 01 and 11 are driven
            remote1_filter_field = i[1] ? 2'b01 : {2{i[0]}};
            remote2_filter_field = {2{~i[0]}};
            wr(8'h31, o1);
            wr(8'h32, o2);
            cmp_out(remote1_offset, o1);
            cmp_out(remote2_offset, o2);
            rd(8'h31, o1);
            conv(a, b);
            wr(8'h19, o2);
            x = ev(a, o1);
            y = ev(b, o2);
            rd(8'h19, x[12:5]);
            rd(8'h1a, y[12:5]);
            conv(b, a);
            rd(8'h29, lo(x, remote1_filter_field));
            rd(8'h2a, lo(y, remote2_filter_field));
            rd(8'h29, lo(ev(b, o1), remote1_filter_field));
        end
        repeat (3) @(posedge clk_sys);
        give_verdict();
    end
endmodule // rtcr_regs_tb
bind rtcr_regs rtcr_regs_assertions i_chk (.*);
`default_nettype wire
